// File: verilog/upc_pkg.sv
// upc_pkg: constants, field positions and carriers for the pipe control
// register block; assumes a 16-bit cpu register port on sys_clk.
package upc_pkg;

  // register layout
  localparam int unsigned UPC_REG_W = 16;
  localparam int unsigned UPC_BIT_BUF_ACCESS = 15;
  localparam int unsigned UPC_BIT_SPLIT_CLR = 13;
  localparam int unsigned UPC_BIT_SPLIT_FLAG = 12;
  localparam int unsigned UPC_BIT_AUTO_CLR = 9;
  localparam int unsigned UPC_BIT_FORCE_ZERO = 8;
  localparam int unsigned UPC_BIT_FORCE_ONE = 7;
  localparam int unsigned UPC_BIT_TOGGLE = 6;
  localparam int unsigned UPC_BIT_ACTIVE = 5;
  localparam int unsigned UPC_RESP_LSB = 0;
  localparam int unsigned UPC_RESP_W = 2;

  // reset values
  localparam logic [UPC_REG_W-1:0] UPC_READ_ZERO = 16'h0000;
  localparam logic UPC_AUTO_CLR_RST = 1'h0;
  localparam logic UPC_TOGGLE_RST = 1'h0;
  localparam logic UPC_SPLIT_RST = 1'h0;

  // response select codes
  localparam logic [UPC_RESP_W-1:0] UPC_SEL_NAK = 2'h0;
  localparam logic [UPC_RESP_W-1:0] UPC_SEL_BUF = 2'h1;
  localparam logic [UPC_RESP_W-1:0] UPC_SEL_STALL_A = 2'h2;
  localparam logic [UPC_RESP_W-1:0] UPC_SEL_STALL_B = 2'h3;

  // transfer type of the pipe
  typedef enum logic [1:0] {
    UPC_TYPE_OFF  = 2'h0,
    UPC_TYPE_BULK = 2'h1,
    UPC_TYPE_INTR = 2'h2,
    UPC_TYPE_ISO  = 2'h3
  } upc_type_t;

  // token kind from the link side
  typedef enum logic [1:0] {
    UPC_TOK_OUT  = 2'h0,
    UPC_TOK_IN   = 2'h1,
    UPC_TOK_PING = 2'h2,
    UPC_TOK_NONE = 2'h3
  } upc_token_t;

  // handshake answer to a token
  typedef enum logic [2:0] {
    UPC_ANS_SILENT = 3'h0,
    UPC_ANS_NAK    = 3'h1,
    UPC_ANS_ACK    = 3'h2,
    UPC_ANS_NYET   = 3'h3,
    UPC_ANS_STALL  = 3'h4,
    UPC_ANS_DATA   = 3'h5,
    UPC_ANS_ZLP    = 3'h6,
    UPC_ANS_DROP   = 3'h7
  } upc_answer_t;

  // pipe setup and buffer state seen by the block
  typedef struct packed {
    upc_type_t xfer_type;
    logic dir_tx;
    logic host_mode;
    logic buf_rx_ok;
    logic buf_tx_ok;
    logic buf_last_space;
  } upc_pipe_t;

  // one token offered by the link engine
  typedef struct packed {
    logic valid;
    upc_token_t kind;
  } upc_tok_t;

endpackage

// File: verilog/upc_pipe_ctrl.sv
// upc_pipe_ctrl: one pipe's control and status register with split,
// toggle, auto buffer clear and handshake select logic.
// assumes cpu port and link engine signals are on sys_clk already.
// Notes on behaviour
// - bit 15 reads 1 when the cpu may access the pipe buffer.
// - writing 1 to bit 13 clears the split flag; 0 does nothing.
// - bit 12 reads 1 during complete-split, else 0.
// - bit 9 is a read/write auto buffer clear mode bit.
// - writing 1 then 0 to bit 9 discards all pipe buffer content.
// - in host mode, auto clear on interrupt pipe resets interval count.
// - auto clear also resets ready-on-finish and transaction count flags.
// - writing 1 to bit 8 forces next toggle to DATA0; reads 0.
// - writing 1 to bit 7 forces next toggle to DATA1 unless bit 8 is also 1; reads 0.
// - bit 6 shows the expected next toggle, updated by hardware.
// - bit 5 reads 1 while the current bus transaction uses the pipe.
// - bits 1-0 select NAK, buffer-driven or STALL; both sides write.
// - NAK select: bulk/interrupt answer NAK; iso or disabled stay silent.
// - buffer select, bulk receive: ACK or NYET if room, else NAK.
// - STALL select: bulk/interrupt answer STALL; iso stays silent.
`timescale 1ns/100ps

module upc_pipe_ctrl
  import upc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // cpu register port
  input wire logic reg_wr,
  input wire logic [UPC_REG_W-1:0] reg_wdata,
  output logic [UPC_REG_W-1:0] reg_rdata_q,
  // pipe setup and buffer state
  input wire upc_pipe_t pipe_cfg,
  input wire logic buf_access,
  input wire logic pipe_active,
  // link engine events
  input wire logic split_enter_cs,
  input wire logic split_leave_cs,
  input wire logic toggle_advance,
  input wire logic hw_set_nak,
  input wire upc_tok_t token,
  // answers and clear strobes
  output logic ans_valid_q,
  output upc_answer_t ans_code_q,
  output logic toggle_q,
  output logic buf_clear_q,
  output logic interval_reset_q,
  output logic finish_flag_reset_q,
  output logic count_flag_reset_q
);

  // stall codes share one meaning
  function automatic logic is_stall(input logic [UPC_RESP_W-1:0] sel);
    is_stall = (sel == UPC_SEL_STALL_A) || (sel == UPC_SEL_STALL_B);
  endfunction

  // answer for a token given select, setup and buffer state
  function automatic upc_answer_t answer_of(
    input logic [UPC_RESP_W-1:0] sel,
    input upc_pipe_t cfg,
    input upc_token_t kind
  );
    logic hs_pipe;
    hs_pipe = (cfg.xfer_type == UPC_TYPE_BULK) ||
              (cfg.xfer_type == UPC_TYPE_INTR);
    answer_of = UPC_ANS_SILENT;
    if (!hs_pipe) begin
      // iso and disabled pipes never handshake
      if (sel == UPC_SEL_BUF && cfg.xfer_type == UPC_TYPE_ISO) begin
        if (cfg.dir_tx)
          answer_of = cfg.buf_tx_ok ? UPC_ANS_DATA : UPC_ANS_ZLP;
        else if (kind == UPC_TOK_OUT)
          answer_of = cfg.buf_rx_ok ? UPC_ANS_SILENT : UPC_ANS_DROP;
      end
    end else if (is_stall(sel)) begin
      answer_of = UPC_ANS_STALL;
    end else if (sel == UPC_SEL_NAK) begin
      answer_of = UPC_ANS_NAK;
    end else if (cfg.dir_tx) begin
      answer_of = cfg.buf_tx_ok ? UPC_ANS_DATA : UPC_ANS_NAK;
    end else if (!cfg.buf_rx_ok) begin
      answer_of = UPC_ANS_NAK;
    end else if (kind == UPC_TOK_PING) begin
      answer_of = UPC_ANS_ACK;
    end else if (cfg.xfer_type == UPC_TYPE_BULK && cfg.buf_last_space) begin
      answer_of = UPC_ANS_NYET;
    end else begin
      answer_of = UPC_ANS_ACK;
    end
  endfunction

  // register state
  logic split_q, split_d;
  logic auto_clr_q, auto_clr_d;
  logic toggle_d;
  logic [UPC_RESP_W-1:0] sel_q, sel_d;
  logic [UPC_REG_W-1:0] reg_rdata_d;
  logic buf_clear_d, interval_reset_d;
  logic finish_flag_reset_d, count_flag_reset_d;
  logic ans_valid_d;
  upc_answer_t ans_code_d;
  logic wr_split_clr, wr_zero, wr_one, clr_fire;

  // write strobes act only in the write cycle, nothing is kept
  // one-cycle triggers
  assign wr_split_clr = reg_wr && reg_wdata[UPC_BIT_SPLIT_CLR];
  assign wr_zero = reg_wr && reg_wdata[UPC_BIT_FORCE_ZERO];
  assign wr_one = reg_wr && reg_wdata[UPC_BIT_FORCE_ONE];

  // auto clear fires on the 1 then 0 write of the mode bit
  // falling mode bit
  assign clr_fire = reg_wr && auto_clr_q && !reg_wdata[UPC_BIT_AUTO_CLR];

  // next state of the control and status bits
  always_comb begin
    split_d = split_q;
    if (wr_split_clr)
      split_d = 1'b0;
    if (split_leave_cs)
      split_d = 1'b0;
    if (split_enter_cs)
      split_d = 1'b1; // a set beats a same-cycle clear

    auto_clr_d = reg_wr ? reg_wdata[UPC_BIT_AUTO_CLR] : auto_clr_q;

    toggle_d = toggle_q;
    if (toggle_advance)
      toggle_d = ~toggle_q;
    if (wr_zero)
      toggle_d = 1'b0;
    if (wr_one && !wr_zero)
      toggle_d = 1'b1;

    sel_d = sel_q;
    if (reg_wr)
      sel_d = reg_wdata[UPC_RESP_LSB +: UPC_RESP_W];
    if (hw_set_nak)
      sel_d = UPC_SEL_NAK; // hardware set wins over software
  end

  // registers of the control and status bits
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      split_q <= UPC_SPLIT_RST;
      auto_clr_q <= UPC_AUTO_CLR_RST;
      toggle_q <= UPC_TOGGLE_RST;
      sel_q <= UPC_SEL_NAK;
    end else begin
      split_q <= split_d;
      auto_clr_q <= auto_clr_d;
      toggle_q <= toggle_d;
      sel_q <= sel_d;
    end
  end

  // clear strobes and read data
  always_comb begin
    buf_clear_d = clr_fire;
    interval_reset_d = clr_fire && pipe_cfg.host_mode &&
                       (pipe_cfg.xfer_type == UPC_TYPE_INTR);
    finish_flag_reset_d = clr_fire;
    count_flag_reset_d = clr_fire;

    reg_rdata_d = UPC_READ_ZERO;
    reg_rdata_d[UPC_BIT_BUF_ACCESS] = buf_access;
    reg_rdata_d[UPC_BIT_SPLIT_FLAG] = split_q;
    reg_rdata_d[UPC_BIT_AUTO_CLR] = auto_clr_q;
    reg_rdata_d[UPC_BIT_TOGGLE] = toggle_q;
    reg_rdata_d[UPC_BIT_ACTIVE] = pipe_active;
    reg_rdata_d[UPC_RESP_LSB +: UPC_RESP_W] = sel_q;
  end

  // registers of the strobes and read data
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_clear_q <= 1'b0;
      interval_reset_q <= 1'b0;
      finish_flag_reset_q <= 1'b0;
      count_flag_reset_q <= 1'b0;
      reg_rdata_q <= UPC_READ_ZERO;
    end else begin
      buf_clear_q <= buf_clear_d;
      interval_reset_q <= interval_reset_d;
      finish_flag_reset_q <= finish_flag_reset_d;
      count_flag_reset_q <= count_flag_reset_d;
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // token answer, one cycle after the token
  always_comb begin
    ans_valid_d = token.valid && (token.kind != UPC_TOK_NONE);
    ans_code_d = UPC_ANS_SILENT;
    if (ans_valid_d)
      ans_code_d = answer_of(sel_q, pipe_cfg, token.kind);
  end

  // answer registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ans_valid_q <= 1'b0;
      ans_code_q <= UPC_ANS_SILENT;
    end else begin
      ans_valid_q <= ans_valid_d;
      ans_code_q <= ans_code_d;
    end
  end

endmodule

// File: test/upc_pipe_ctrl_assertions.sv
// upc_pipe_ctrl_assertions: port checks for the pipe control block
// assumes it is bound onto upc_pipe_ctrl, one clock domain
`timescale 1ns/100ps
module upc_pipe_ctrl_assertions
  import upc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // inputs watched
  input wire logic reg_wr,
  input wire logic [UPC_REG_W-1:0] reg_wdata,
  input wire upc_pipe_t pipe_cfg,
  input wire logic buf_access,
  input wire logic split_enter_cs,
  input wire logic hw_set_nak,
  // outputs watched
  input wire logic [UPC_REG_W-1:0] reg_rdata_q,
  input wire logic toggle_q,
  input wire logic buf_clear_q,
  input wire logic interval_reset_q,
  input wire logic finish_flag_reset_q,
  input wire logic count_flag_reset_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // assertions on the register image and strobes
  zero_bits_a: assert property ((reg_rdata_q & 16'h6d9c) == 16'h0000)
    else $error("fixed zero bit reads 1");
  split_clr_a: assert property (
    reg_wr && reg_wdata[13] && !split_enter_cs |-> ##2 !reg_rdata_q[12])
    else $error("split flag not cleared");
  zero_force_a: assert property (reg_wr && reg_wdata[8] |=> !toggle_q)
    else $error("toggle not forced to 0");
  one_force_a: assert property (
    reg_wr && reg_wdata[7] && !reg_wdata[8] |=> toggle_q)
    else $error("toggle not forced to 1");
  toggle_mon_a: assert property (reg_rdata_q[6] == $past(toggle_q))
    else $error("toggle image wrong");
  aclr_fire_a: assert property (
    buf_clear_q |-> $past(reg_wr) && !$past(reg_wdata[9]))
    else $error("buffer clear without write");
  aclr_flags_a: assert property (
    buf_clear_q |-> finish_flag_reset_q && count_flag_reset_q)
    else $error("flag resets missing");
  interval_clr_a: assert property (interval_reset_q == (buf_clear_q &&
    $past(pipe_cfg.host_mode) && $past(pipe_cfg.xfer_type) == UPC_TYPE_INTR))
    else $error("interval reset wrong");
  clr_pulse_a: assert property (buf_clear_q |=> !buf_clear_q)
    else $error("clear strobe held");
  hw_nak_a: assert property (
    hw_set_nak |-> ##2 reg_rdata_q[1:0] == UPC_SEL_NAK)
    else $error("select not forced to nak");
  buf_access_a: assert property (
    $rose(buf_access) |-> ##[1:2] reg_rdata_q[15])
    else $error("buffer access bit missing");
  // main scenarios reached
  cover property (buf_clear_q);
  cover property (interval_reset_q);
  cover property (hw_set_nak);
endmodule

bind upc_pipe_ctrl upc_pipe_ctrl_assertions chk (.sys_clk(sys_clk),
  .rst_b(rst_b), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .pipe_cfg(pipe_cfg), .buf_access(buf_access),
  .split_enter_cs(split_enter_cs), .hw_set_nak(hw_set_nak),
  .reg_rdata_q(reg_rdata_q), .toggle_q(toggle_q),
  .buf_clear_q(buf_clear_q), .interval_reset_q(interval_reset_q),
  .finish_flag_reset_q(finish_flag_reset_q),
  .count_flag_reset_q(count_flag_reset_q));

// File: test/upc_host_model.sv
// upc_host_model: bus side that offers tokens to the pipe
// assumes the bench calls offer from its own thread
`timescale 1ns/100ps
module upc_host_model
  import upc_pkg::*;
(
  // clock and token out
  input wire logic sys_clk,
  output upc_tok_t token
);
  // idle slots carry the no-token kind
  initial token = '{1'b0, UPC_TOK_NONE};
  // one token for one cycle, then idle again
  task automatic offer(input upc_token_t k);
    @(posedge sys_clk) token <= '{1'b1, k};
    @(posedge sys_clk) token <= '{1'b0, UPC_TOK_NONE};
  endtask
endmodule

// File: test/upc_pipe_ctrl_tb.sv
// upc_pipe_ctrl_tb: directed tests for the pipe control register
// assumes the checker is bound and the host model sends tokens
`timescale 1ns/100ps
module upc_pipe_ctrl_tb
  import upc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  upc_pipe_t pipe_cfg = '0;
  logic buf_access = 1'b0;
  logic pipe_active = 1'b0;
  logic split_enter_cs = 1'b0;
  logic toggle_advance = 1'b0;
  logic hw_set_nak = 1'b0;
  upc_tok_t token;
  logic [15:0] reg_rdata_q;
  logic ans_valid_q, toggle_q, buf_clear_q, interval_reset_q, fin_q, cnt_q;
  upc_answer_t ans_code_q;
  upc_answer_t exp_ans[4] = '{UPC_ANS_NAK, UPC_ANS_ACK, UPC_ANS_STALL,
    UPC_ANS_STALL};
  int bad_count = 0;
  int comparisons = 0;
  // clock and parts
  always #10 sys_clk = ~sys_clk;
  upc_host_model host (.sys_clk(sys_clk), .token(token));
  upc_pipe_ctrl DUT (.sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .pipe_cfg(pipe_cfg),
    .buf_access(buf_access), .pipe_active(pipe_active),
    .split_enter_cs(split_enter_cs), .split_leave_cs(1'b0),
    .toggle_advance(toggle_advance), .hw_set_nak(hw_set_nak),
    .token(token), .ans_valid_q(ans_valid_q), .ans_code_q(ans_code_q),
    .toggle_q(toggle_q), .buf_clear_q(buf_clear_q),
    .interval_reset_q(interval_reset_q), .finish_flag_reset_q(fin_q),
    .count_flag_reset_q(cnt_q));
  // shared helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // write taken at second edge; state and strobes visible on return,
  // register image one edge later
  task automatic wr(input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic t_aclr;
    pipe_cfg <= '{UPC_TYPE_INTR, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    // mode bit moved with split 0, select NAK
    wr(16'h0200);
    step(1);
    chk(reg_rdata_q, 16'h0200);
    wr(16'h0000);
    chk({buf_clear_q, interval_reset_q, fin_q, cnt_q}, 16'h000f);
    step(1);
    chk({buf_clear_q, interval_reset_q}, 16'h0000);
    pipe_cfg.xfer_type <= UPC_TYPE_BULK;
    wr(16'h0200);
    wr(16'h0000);
    chk({buf_clear_q, interval_reset_q, cnt_q}, 16'h0005);
    $display("auto clear test done");
  endtask
  task automatic t_toggle;
    wr(16'h0080);
    chk(toggle_q, 1'b1);
    step(1);
    chk(reg_rdata_q, 16'h0040);
    wr(16'h0180);
    chk(toggle_q, 1'b0);
    @(posedge sys_clk) toggle_advance <= 1'b1;
    @(posedge sys_clk) toggle_advance <= 1'b0;
    step(1);
    chk(reg_rdata_q, 16'h0040);
    $display("toggle test done");
  endtask
  task automatic t_split;
    @(posedge sys_clk) split_enter_cs <= 1'b1;
    @(posedge sys_clk) split_enter_cs <= 1'b0;
    step(1);
    chk(reg_rdata_q[12], 1'b1);
    wr(16'h0000);
    step(1);
    chk(reg_rdata_q[12], 1'b1);
    wr(16'h2000);
    step(1);
    chk(reg_rdata_q[12], 1'b0);
    $display("split test done");
  endtask
  task automatic t_resp;
    for (int i = 0; i < 4; i++) begin
      wr(i[15:0]);
      host.offer(UPC_TOK_OUT);
      #1;
      chk({ans_valid_q, ans_code_q}, {1'b1, exp_ans[i]});
    end
    wr(16'h0001);
    pipe_cfg.buf_rx_ok <= 1'b0;
    host.offer(UPC_TOK_OUT);
    #1;
    chk(ans_code_q, UPC_ANS_NAK);
    pipe_cfg.xfer_type <= UPC_TYPE_ISO;
    wr(16'h0002);
    host.offer(UPC_TOK_IN);
    #1;
    chk(ans_code_q, UPC_ANS_SILENT);
    pipe_cfg.xfer_type <= UPC_TYPE_OFF;
    wr(16'h0000);
    host.offer(UPC_TOK_OUT);
    #1;
    chk(ans_code_q, UPC_ANS_SILENT);
    // hardware NAK set overrides the written buffer select
    wr(16'h0001);
    @(posedge sys_clk) hw_set_nak <= 1'b1;
    @(posedge sys_clk) hw_set_nak <= 1'b0;
    step(1);
    chk(reg_rdata_q[1:0], UPC_SEL_NAK);
    $display("response test done");
  endtask
  task automatic t_levels;
    buf_access <= 1'b1;
    pipe_active <= 1'b1;
    step(3);
    chk(reg_rdata_q & 16'h8020, 16'h8020);
    $display("status test done");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    step(1);
    chk(reg_rdata_q, 16'h0000);
    t_aclr();
    t_toggle();
    t_split();
    t_resp();
    t_levels();
    results();
  end
  // watchdog
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    results();
  end
endmodule
